// [rtl/clk_fm_tick_defs.vh]
// Constants for the watchdog clock mux, FM control and periodic tick timer
`ifndef CLK_FM_TICK_DEFS_VH
`define CLK_FM_TICK_DEFS_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_CLOCK_SELECT   8'h09
`define IDX_PLL_FM_CTRL    8'h0a
`define IDX_TICK_CTRL      8'h0b
`define IDX_OSC_STATUS     8'h10
`define IDX_INT_STATUS     8'h11
`define IDX_INT_MASK       8'h12
`define IDX_PROTECT        8'h13

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_CLOCK_SELECT   8'h80
`define RST_PLL_FM_CTRL    8'h00
`define RST_TICK_CTRL      8'h00
`define RST_INT_MASK       2'h0
`define RST_PROTECT        1'b0

// ----------------------------------------------------------------------
// Clock select register fields
// ----------------------------------------------------------------------
`define CS_PLL_SEL         7
`define CS_PSEUDO_STOP     6
`define CS_WDOG_HI         4
`define CS_TICK_SEL        1
`define CS_WDOG_LO         0

// ----------------------------------------------------------------------
// PLL FM control fields
// ----------------------------------------------------------------------
`define FM_AMP_HI          5
`define FM_AMP_LO          4
`define FM_AMP_OFF         2'h0
`define FM_AMP_PM1         2'h1
`define FM_AMP_PM2         2'h2
`define FM_AMP_PM4         2'h3
`define FM_REF_DIV         16
`define FM_HALF_CNT        3'h7

// ----------------------------------------------------------------------
// Tick control fields
// ----------------------------------------------------------------------
`define TK_DEC             7
`define TK_PRE_HI          6
`define TK_PRE_LO          4
`define TK_MOD_HI          3
`define TK_MOD_LO          0
`define TK_BIN_SHIFT_BASE  5'h09
`define TK_PRE_OFF         3'h0

// ----------------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------------
`define INT_TICK           0
`define INT_LOCK           1

`endif

// [rtl/fm_modulator.v]
// Frequency modulation sequencer for the VCO clock
`timescale 1ns/100ps
`default_nettype none
`include "clk_fm_tick_defs.vh"

module fm_modulator (
   input  wire       core_clk,
   input  wire       rst_b,
   input  wire       refEdge,
   input  wire [1:0] fmAmp,
   output reg        fmEnable_q,
   output reg  [1:0] fmAmpOut_q,
   output reg        fmDir_q
);

   reg [2:0] refCnt_q;

   // ------------------------------------------------------------------
   // Triangle direction toggles every 8 reference edges
   // ------------------------------------------------------------------
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         refCnt_q   <= 3'h0;
         fmDir_q    <= 1'b0;
         fmEnable_q <= 1'b0;
         fmAmpOut_q <= `FM_AMP_OFF;
      end else begin
         fmEnable_q <= (fmAmp != `FM_AMP_OFF);
         fmAmpOut_q <= fmAmp;
         if (fmAmp == `FM_AMP_OFF) begin
            refCnt_q <= 3'h0;
            fmDir_q  <= 1'b0;
         end else if (refEdge) begin
            refCnt_q <= refCnt_q + 3'h1;
            if (refCnt_q == `FM_HALF_CNT) begin
               fmDir_q <= ~fmDir_q;
            end
         end
      end
   end

endmodule
`default_nettype wire

// [rtl/tick_divider.v]
// Prescaler and modulus counter of the periodic tick timer
`timescale 1ns/100ps
`default_nettype none
`include "clk_fm_tick_defs.vh"

module tick_divider (
   input  wire       core_clk,
   input  wire       rst_b,
   input  wire       srcEdge,
   input  wire       run,
   input  wire       restart,
   input  wire [7:0] ctrl,
   output reg        tickEvent_q
);

   reg  [21:0] cnt_q;
   wire [21:0] ratio;
   wire        off;

   // ------------------------------------------------------------------
   // Divide ratio decode
   // ------------------------------------------------------------------
   function [21:0] divRatio;
      input [7:0] c;
      reg   [21:0] base;
      reg   [21:0] mult;
      begin
         base = 22'h0;
         mult = {18'h0, c[`TK_MOD_HI:`TK_MOD_LO]} + 22'h1;
         if (c[`TK_DEC]) begin
            case (c[`TK_PRE_HI:`TK_PRE_LO])
               3'h0:    base = 22'd1000;
               3'h1:    base = 22'd2000;
               3'h2:    base = 22'd5000;
               3'h3:    base = 22'd10000;
               3'h4:    base = 22'd20000;
               3'h5:    base = 22'd50000;
               3'h6:    base = 22'd100000;
               default: base = 22'd200000;
            endcase
         end else begin
            base = 22'h1 << ({2'h0, c[`TK_PRE_HI:`TK_PRE_LO]}
                             + `TK_BIN_SHIFT_BASE);
         end
         divRatio = base * mult;
      end
   endfunction

   assign ratio = divRatio(ctrl);
   assign off   = !ctrl[`TK_DEC] &&
                  (ctrl[`TK_PRE_HI:`TK_PRE_LO] == `TK_PRE_OFF);

   // ------------------------------------------------------------------
   // Counter
   // ------------------------------------------------------------------
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q       <= 22'h0;
         tickEvent_q <= 1'b0;
      end else begin
         tickEvent_q <= 1'b0;
         if (restart || off) begin
            cnt_q <= 22'h0;
         end else if (run && srcEdge) begin
            if (cnt_q >= ratio - 22'h1) begin
               cnt_q       <= 22'h0;
               tickEvent_q <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 22'h1;
            end
         end
      end
   end

endmodule
`default_nettype wire

// [rtl/clock_fm_and_periodic_tick_ctrl.v]
// Watchdog clock mux, PLL FM control and periodic tick timer with AHB-Lite
//
// What this block does
// - Watchdog clock: 00 internal RC, 01 oscillator, 1x auxiliary RC.
// - PLL FM register written only when unprotected and PLL source selected.
// - Accepted PLL FM write clears PLL lock and oscillator-up flags.
// - FM modulates VCO at reference frequency divided by 16.
// - FM amplitude code: off, 1, 2, 4 percent.
// - Tick clock: internal RC when select 0, oscillator when 1.
// - In stop, tick runs only with pseudo stop and oscillator source.
// - Any tick control write starts a new time-out period.
// - Tick source select change restarts the time-out period.
// - Bit 7 picks binary or decimal prescaler family.
// - Binary prescale codes 001..111 give 2^10..2^16.
// - Modulus field plus one multiplies the prescaler into the ratio.
// - Binary prescale 000 turns the tick off; reset default.
// - Decimal prescale codes give 1,2,5,10,20,50,100,200 thousand.
// - Tick source select set only with oscillator up; cleared on loss.
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "clk_fm_tick_defs.vh"

module clock_fm_and_periodic_tick_ctrl (
   input  wire        core_clk,
   input  wire        rst_b,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   input  wire        internalRcClock,
   input  wire        crystalOscClock,
   input  wire        auxRcClock,
   input  wire        pllRefClock,
   input  wire        stopMode,
   input  wire        oscUpSet,
   input  wire        oscLost,
   input  wire        pllLockSet,
   input  wire        pllUnlock,
   output reg         watchdogClock,
   output wire        fmEnable,
   output wire [1:0]  fmAmplitude,
   output wire        fmDirection,
   output wire        tickPulse,
   output wire        irq
);

   // ------------------------------------------------------------------
   // Registers and wires
   // ------------------------------------------------------------------
   reg  [7:0]  clkSel_q;
   reg  [7:0]  pllFm_q;
   reg  [7:0]  tickCtrl_q;
   reg         protect_q;
   reg         oscUp_q;
   reg         pllLock_q;
   reg  [1:0]  intStat_q;
   reg  [1:0]  intMask_q;
   reg         wrPend_q;
   reg  [7:0]  wrIdx_q;
   reg         prevTickSel_q;
   reg         prevIrc_q;
   reg         prevOsc_q;
   reg         prevRef_q;
   reg         lockSeen_q;
   wire        addrPhase;
   wire [7:0]  addrIdx;
   wire        wrClkSel;
   wire        wrPll;
   wire        pllAccept;
   wire        wrTick;
   wire        wrIntStat;
   wire        wrIntMask;
   wire        wrProtect;
   wire        tickSel;
   wire        tickSrcEdge;
   wire        tickRun;
   wire        tickRestart;
   wire        refEdge;
   wire        tickEvent;
   wire        lockEvent;
   reg  [7:0]  rdData;

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function rise;
      input lvl;
      input prevLvl;
      begin
         rise = lvl && !prevLvl;
      end
   endfunction

   function inMap;
      input [31:0] a;
      begin
         inMap = (a[31:10] == 22'h0);
      end
   endfunction

   // ------------------------------------------------------------------
   // AHB-Lite slave, zero wait states, always OKAY
   // ------------------------------------------------------------------
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign addrPhase = hsel && htrans[1] && hready;
   assign addrIdx   = haddr[9:2];

   always @* begin
      rdData = 8'h00;
      if (inMap(haddr)) begin
         case (addrIdx)
            `IDX_CLOCK_SELECT: rdData = clkSel_q;
            `IDX_PLL_FM_CTRL:  rdData = {2'h0, pllFm_q[5:4], 4'h0};
            `IDX_TICK_CTRL:    rdData = tickCtrl_q;
            `IDX_OSC_STATUS:   rdData = {6'h0, pllLock_q, oscUp_q};
            `IDX_INT_STATUS:   rdData = {6'h0, intStat_q};
            `IDX_INT_MASK:     rdData = {6'h0, intMask_q};
            `IDX_PROTECT:      rdData = {7'h0, protect_q};
            default:           rdData = 8'h00;
         endcase
      end
   end

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wrPend_q <= 1'b0;
         wrIdx_q  <= 8'h00;
         hrdata   <= 32'h0;
      end else begin
         wrPend_q <= addrPhase && hwrite && inMap(haddr);
         if (addrPhase) begin
            wrIdx_q <= addrIdx;
         end
         if (addrPhase && !hwrite) begin
            hrdata <= {24'h0, rdData};
         end
      end
   end

   assign wrClkSel  = wrPend_q && (wrIdx_q == `IDX_CLOCK_SELECT);
   assign wrPll     = wrPend_q && (wrIdx_q == `IDX_PLL_FM_CTRL);
   assign wrTick    = wrPend_q && (wrIdx_q == `IDX_TICK_CTRL);
   assign wrIntStat = wrPend_q && (wrIdx_q == `IDX_INT_STATUS);
   assign wrIntMask = wrPend_q && (wrIdx_q == `IDX_INT_MASK);
   assign wrProtect = wrPend_q && (wrIdx_q == `IDX_PROTECT);
   assign pllAccept = wrPll && !protect_q &&
                      clkSel_q[`CS_PLL_SEL];

   // ------------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------------
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         clkSel_q   <= `RST_CLOCK_SELECT;
         pllFm_q    <= `RST_PLL_FM_CTRL;
         tickCtrl_q <= `RST_TICK_CTRL;
         protect_q  <= `RST_PROTECT;
         intMask_q  <= `RST_INT_MASK;
      end else begin
         if (wrClkSel) begin
            clkSel_q[7:2]         <= hwdata[7:2];
            clkSel_q[`CS_TICK_SEL] <= hwdata[`CS_TICK_SEL] &&
                                      oscUp_q;
            clkSel_q[`CS_WDOG_LO]  <= hwdata[`CS_WDOG_LO] && oscUp_q;
         end
         if (!oscUp_q) begin
            clkSel_q[`CS_TICK_SEL] <= 1'b0;
            clkSel_q[`CS_WDOG_LO]  <= 1'b0;
         end
         if (pllAccept) begin
            pllFm_q <= {2'h0, hwdata[`FM_AMP_HI:`FM_AMP_LO],
                        4'h0};
         end
         if (wrTick) begin
            tickCtrl_q <= hwdata[7:0];
         end
         if (wrProtect) begin
            protect_q <= hwdata[0];
         end
         if (wrIntMask) begin
            intMask_q <= hwdata[1:0];
         end
      end
   end

   // ------------------------------------------------------------------
   // Oscillator-up and lock flags; hardware set wins over clear
   // ------------------------------------------------------------------
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         oscUp_q    <= 1'b0;
         pllLock_q  <= 1'b0;
         lockSeen_q <= 1'b0;
      end else begin
         if (oscUpSet) begin
            oscUp_q <= 1'b1;
         end else if (pllAccept || oscLost) begin
            oscUp_q <= 1'b0;
         end
         if (pllLockSet) begin
            pllLock_q <= 1'b1;
         end else if (pllAccept || pllUnlock) begin
            pllLock_q <= 1'b0;
         end
         lockSeen_q <= pllLock_q;
      end
   end

   // ------------------------------------------------------------------
   // Source clock edge detection
   // ------------------------------------------------------------------
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         prevIrc_q     <= 1'b0;
         prevOsc_q     <= 1'b0;
         prevRef_q     <= 1'b0;
         prevTickSel_q <= 1'b0;
      end else begin
         prevIrc_q     <= internalRcClock;
         prevOsc_q     <= crystalOscClock;
         prevRef_q     <= pllRefClock;
         prevTickSel_q <= tickSel;
      end
   end

   assign tickSel     = clkSel_q[`CS_TICK_SEL];
   assign tickSrcEdge = tickSel ? rise(crystalOscClock, prevOsc_q)
                                : rise(internalRcClock, prevIrc_q);
   assign tickRun     = !stopMode ||
                        (clkSel_q[`CS_PSEUDO_STOP] && tickSel);
   assign tickRestart = wrTick ||
                        (tickSel != prevTickSel_q);
   assign refEdge     = rise(pllRefClock, prevRef_q);

   // ------------------------------------------------------------------
   // Watchdog clock multiplexer
   // ------------------------------------------------------------------
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         watchdogClock <= 1'b0;
      end else if (clkSel_q[`CS_WDOG_HI]) begin
         watchdogClock <= auxRcClock;
      end else if (clkSel_q[`CS_WDOG_LO]) begin
         watchdogClock <= crystalOscClock;
      end else begin
         watchdogClock <= internalRcClock;
      end
   end

   // ------------------------------------------------------------------
   // Submodules
   // ------------------------------------------------------------------
   fm_modulator uFm (
      .core_clk   (core_clk),
      .rst_b      (rst_b),
      .refEdge    (refEdge),
      .fmAmp      (pllFm_q[`FM_AMP_HI:`FM_AMP_LO]),
      .fmEnable_q (fmEnable),
      .fmAmpOut_q (fmAmplitude),
      .fmDir_q    (fmDirection)
   );

   tick_divider uTick (
      .core_clk    (core_clk),
      .rst_b       (rst_b),
      .srcEdge     (tickSrcEdge),
      .run         (tickRun),
      .restart     (tickRestart),
      .ctrl        (tickCtrl_q),
      .tickEvent_q (tickEvent)
   );

   assign tickPulse = tickEvent;
   assign lockEvent = rise(pllLock_q, lockSeen_q);

   // ------------------------------------------------------------------
   // Interrupt status, write one to clear, set wins
   // ------------------------------------------------------------------
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         intStat_q <= 2'h0;
      end else begin
         if (tickEvent) begin
            intStat_q[`INT_TICK] <= 1'b1;
         end else if (wrIntStat && hwdata[`INT_TICK]) begin
            intStat_q[`INT_TICK] <= 1'b0;
         end
         if (lockEvent) begin
            intStat_q[`INT_LOCK] <= 1'b1;
         end else if (wrIntStat && hwdata[`INT_LOCK]) begin
            intStat_q[`INT_LOCK] <= 1'b0;
         end
      end
   end

   assign irq = |(intStat_q & intMask_q);

endmodule
`default_nettype wire

// [test/clock_fm_tick_monitor.sv]
// Port checker for the clock, FM and tick control block
`timescale 1ns/100ps
`default_nettype none
module clock_fm_tick_monitor (
   input wire logic        core_clk,
   input wire logic        rst_b,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        pllRefClock,
   input wire logic        fmEnable,
   input wire logic [1:0]  fmAmplitude,
   input wire logic        fmDirection,
   input wire logic        tickPulse
);
   // -------
   // Helpers
   // -------
   logic        refPrev_q, dirPrev_q, armed_q, refEdge, dirFlip;
   logic [1:0]  ampPrev_q;
   logic [4:0]  refCnt_q;
   logic [15:0] gap_q;
   assign refEdge = pllRefClock & ~refPrev_q;
   assign dirFlip = (fmDirection ^ dirPrev_q) & fmEnable
                    & (fmAmplitude == ampPrev_q);
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         refPrev_q <= 1'b0;
         dirPrev_q <= 1'b0;
         ampPrev_q <= 2'h0;
         armed_q   <= 1'b0;
         refCnt_q  <= 5'h0;
         gap_q     <= 16'h0;
      end else begin
         refPrev_q <= pllRefClock;
         dirPrev_q <= fmDirection;
         ampPrev_q <= fmAmplitude;
         armed_q   <= (armed_q | dirFlip) & fmEnable
                      & (fmAmplitude == ampPrev_q);
         refCnt_q  <= dirFlip ? 5'h0 : refCnt_q + {4'h0, refEdge};
         gap_q     <= tickPulse ? 16'h0 : gap_q + {15'h0, ~&gap_q};
      end
   end
   // ----------
   // Assertions
   // ----------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   AST_BUS_OKAY: assert property (hreadyout && !hresp)
      else $error("bus not ready or not OKAY");
   AST_RD_UPPER: assert property (hrdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   AST_RD_HOLD: assert property
      (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
      else $error("read data moved without a read");
   AST_FM_ENABLE: assert property
      (fmEnable == (fmAmplitude != 2'h0))
      else $error("modulation enable disagrees with amplitude");
   AST_FM_RATE: assert property (dirFlip && armed_q |->
      refCnt_q + {4'h0, refEdge} == 5'd8)
      else $error("modulation half period not eight reference edges");
   AST_TICK_ONE: assert property (tickPulse |=> !tickPulse)
      else $error("tick pulse longer than one cycle");
   AST_TICK_GAP: assert property
      ($rose(tickPulse) |-> gap_q >= 16'd1999)
      else $error("tick pulses too close");
   AST_RST_QUIET: assert property ($rose(rst_b) |->
      !tickPulse && !fmEnable && !fmDirection)
      else $error("outputs active straight after reset");
endmodule
bind clock_fm_and_periodic_tick_ctrl clock_fm_tick_monitor mon (
   .core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .hrdata(hrdata), .pllRefClock(pllRefClock),
   .fmEnable(fmEnable), .fmAmplitude(fmAmplitude),
   .fmDirection(fmDirection), .tickPulse(tickPulse));
`default_nettype wire

// [test/clock_fm_and_periodic_tick_ctrl_test.sv]
// Scenario bench for the clock, FM and tick control block
`timescale 1ns/100ps
`default_nettype none
`include "clk_fm_tick_defs.vh"
module clock_fm_and_periodic_tick_ctrl_test;
   logic        core_clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic        stopMode = 1'b0, oscUpSet = 1'b0, oscLost = 1'b0;
   logic        pllLockSet = 1'b0, internalRcClock = 1'b0;
   logic        crystalOscClock = 1'b0, auxRcClock = 1'b0;
   logic        pllRefClock = 1'b0;
   logic [1:0]  htrans = 2'h0, fmAmplitude;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic        hready, hreadyout, hresp, watchdogClock, fmEnable;
   logic        fmDirection, tickPulse, irq;
   int          cyc = 0, checks = 0, miscompares = 0;
   assign hready = hreadyout;
   always #50 core_clk = ~core_clk;
   // Slow source clocks: periods of 4, 6, 10 and 4 cycles
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      internalRcClock <= cyc[1];
      pllRefClock <= cyc[1];
      crystalOscClock <= (cyc % 6) < 3;
      auxRcClock <= (cyc % 10) < 5;
   end
   clock_fm_and_periodic_tick_ctrl uut (
      .core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .internalRcClock(internalRcClock),
      .crystalOscClock(crystalOscClock), .auxRcClock(auxRcClock),
      .pllRefClock(pllRefClock), .stopMode(stopMode),
      .oscUpSet(oscUpSet), .oscLost(oscLost), .pllLockSet(pllLockSet),
      .pllUnlock(1'b0), .watchdogClock(watchdogClock),
      .fmEnable(fmEnable), .fmAmplitude(fmAmplitude),
      .fmDirection(fmDirection), .tickPulse(tickPulse), .irq(irq));
   // -----
   // Tasks
   // -----
   task automatic chk(input logic [31:0] got, input logic [31:0] want,
                      input int tol);
      checks++;
      if (^got === 1'bx || got + tol < want || got > want + tol) begin
         miscompares++;
         $display("BAD at %0t: got %h expected %h", $time, got, want);
      end
   endtask
   task automatic waitReady;
      int n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (hready !== 1'b1 && n < 64);
      if (n >= 64) conclude(1'b1);
   endtask
   task automatic xfer(input logic w, input logic [7:0] idx,
                       input logic [7:0] d, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {22'h0, idx, 2'h0};
      hwrite <= w;
      waitReady();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      waitReady();
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] rd;
      xfer(1'b1, idx, d, rd);
   endtask
   task automatic rdChk(input logic [7:0] idx, input logic [7:0] want);
      logic [31:0] rd;
      xfer(1'b0, idx, 8'h0, rd);
      chk(rd, {24'h0, want}, 0);
   endtask
   task automatic flags(input logic up, input logic lost, input logic lk);
      oscUpSet <= up;
      oscLost <= lost;
      pllLockSet <= lk;
      @(posedge core_clk);
      oscUpSet <= 1'b0;
      oscLost <= 1'b0;
      pllLockSet <= 1'b0;
   endtask
   // Counts rises (sel 0 watchdog, 2 tick) or toggles (sel 1 direction)
   task automatic countRise(input int sel, input int len, output int n);
      logic v, p;
      n = 0;
      p = (sel == 1) ? fmDirection : 1'b1;
      repeat (len) begin
         @(posedge core_clk);
         v = (sel == 0) ? watchdogClock : (sel == 1) ? fmDirection : tickPulse;
         if ((sel == 1) ? (v !== p) : (v === 1'b1 && p !== 1'b1)) n++;
         p = v;
      end
   endtask
   task automatic waitPulse(output int n);
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (tickPulse !== 1'b1 && n < 40000);
      if (n >= 40000) conclude(1'b1);
   endtask
   task automatic tickRun(input logic [7:0] c, input int want);
      int n;
      wr(`IDX_TICK_CTRL, c);
      waitPulse(n);
      waitPulse(n);
      chk(n, want, 0);
   endtask
   task automatic irqChk(input logic want);
      @(posedge core_clk);
      chk({31'h0, irq}, {31'h0, want}, 0);
   endtask
   // ---------
   // Scenarios
   // ---------
   task automatic testReset;
      rdChk(`IDX_PLL_FM_CTRL, `RST_PLL_FM_CTRL);
      rdChk(`IDX_TICK_CTRL, `RST_TICK_CTRL);
      rdChk(`IDX_CLOCK_SELECT, `RST_CLOCK_SELECT);
      wr(8'hff, 8'h5a);
      rdChk(8'hff, 8'h00);
      $display("end reset values");
   endtask
   task automatic testWdog;
      int n;
      int rate [4] = '{30, 20, 12, 12};
      flags(1'b1, 1'b0, 1'b0);
      for (int i = 0; i < 4; i++) begin
         wr(`IDX_CLOCK_SELECT, {3'h4, i[1], 3'h0, i[0]});
         repeat (8) @(posedge core_clk);
         countRise(0, 120, n);
         chk(n, rate[i], 1);
      end
      $display("end watchdog mux");
   endtask
   task automatic testFm;
      int n;
      logic [1:0] code;
      flags(1'b1, 1'b0, 1'b1);
      wr(`IDX_PROTECT, 8'h01);
      wr(`IDX_PLL_FM_CTRL, 8'h30);
      rdChk(`IDX_PLL_FM_CTRL, 8'h00);
      rdChk(`IDX_OSC_STATUS, 8'h03);
      wr(`IDX_PROTECT, 8'h00);
      wr(`IDX_CLOCK_SELECT, 8'h00);
      wr(`IDX_PLL_FM_CTRL, 8'h30);
      rdChk(`IDX_PLL_FM_CTRL, 8'h00);
      wr(`IDX_CLOCK_SELECT, 8'h80);
      for (int i = 1; i < 5; i++) begin
         code = i[1:0];
         flags(1'b1, 1'b0, 1'b1);
         wr(`IDX_PLL_FM_CTRL, {2'h3, code, 4'hf});
         rdChk(`IDX_PLL_FM_CTRL, {2'h0, code, 4'h0});
         rdChk(`IDX_OSC_STATUS, 8'h00);
         repeat (12) @(posedge core_clk);
         chk({30'h0, fmAmplitude}, {30'h0, code}, 0);
         chk({31'h0, fmEnable}, {31'h0, code != 2'h0}, 0);
         countRise(1, 320, n);
         chk(n, (code != 2'h0) ? 10 : 0, 1);
      end
      $display("end frequency modulation");
   endtask
   task automatic testTick;
      int n;
      tickRun(8'h10, 4096);
      tickRun(8'h20, 8192);
      tickRun(8'h81, 8000);
      wr(`IDX_TICK_CTRL, 8'h10);
      repeat (3000) @(posedge core_clk);
      wr(`IDX_TICK_CTRL, 8'h10);
      waitPulse(n);
      chk(n, 4096, 12);
      wr(`IDX_TICK_CTRL, 8'h0f);
      countRise(2, 5000, n);
      chk(n, 0, 0);
      $display("end tick rates");
   endtask
   task automatic testStop;
      int n;
      wr(`IDX_TICK_CTRL, 8'h10);
      repeat (2000) @(posedge core_clk);
      stopMode <= 1'b1;
      repeat (3000) @(posedge core_clk);
      stopMode <= 1'b0;
      waitPulse(n);
      chk(n, 2096, 12);
      flags(1'b1, 1'b0, 1'b0);
      wr(`IDX_CLOCK_SELECT, 8'hc2);
      rdChk(`IDX_CLOCK_SELECT, 8'hc2);
      stopMode <= 1'b1;
      tickRun(8'h10, 6144);
      stopMode <= 1'b0;
      wr(`IDX_TICK_CTRL, 8'h10);
      repeat (3000) @(posedge core_clk);
      flags(1'b0, 1'b1, 1'b0);
      waitPulse(n);
      chk(n, 4096, 12);
      rdChk(`IDX_CLOCK_SELECT, 8'hc0);
      wr(`IDX_CLOCK_SELECT, 8'h82);
      rdChk(`IDX_CLOCK_SELECT, 8'h80);
      $display("end stop and source loss");
   endtask
   task automatic testIrq;
      wr(`IDX_TICK_CTRL, 8'h00);
      rdChk(`IDX_INT_STATUS, 8'h03);
      irqChk(1'b0);
      wr(`IDX_INT_MASK, 8'h01);
      irqChk(1'b1);
      wr(`IDX_INT_STATUS, 8'h01);
      irqChk(1'b0);
      wr(`IDX_INT_MASK, 8'h02);
      irqChk(1'b1);
      wr(`IDX_INT_STATUS, 8'h02);
      irqChk(1'b0);
      rdChk(`IDX_INT_STATUS, 8'h00);
      rdChk(`IDX_INT_MASK, 8'h02);
      $display("end interrupts");
   endtask
   task automatic conclude(input logic hung);
      if (hung) miscompares++;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      testReset();
      testWdog();
      testFm();
      testTick();
      testStop();
      testIrq();
      conclude(1'b0);
   end
endmodule
`default_nettype wire
